// File: common/irq_pkg.sv
// Constants shared by the interrupt priority and pending stage.
package irq_pkg;

  // ----------------------------------------------------------------
  // Register byte addresses
  // ----------------------------------------------------------------
  localparam logic [31:0] ADDR_ROUTE   = 32'h4020_0004;
  localparam logic [31:0] ADDR_BLOCK   = 32'h4020_0008;
  localparam logic [31:0] ADDR_ORDER   = 32'h4020_000C;
  localparam logic [31:0] ADDR_PENDING = 32'h4020_0010;
  localparam logic [31:0] ADDR_INDEX   = 32'h4020_0014;

  // ----------------------------------------------------------------
  // Reset values and masks
  // ----------------------------------------------------------------
  localparam logic [31:0] RST_ROUTE   = 32'h0000_0000;
  localparam logic [31:0] RST_BLOCK   = 32'hFFFF_FFFF;
  localparam logic [31:0] RST_ORDER   = 32'h0000_007F;
  localparam logic [31:0] RST_PENDING = 32'h0000_0000;
  localparam logic [4:0]  RST_INDEX   = 5'h00;
  localparam logic [31:0] ORDER_MASK  = 32'h001F_FFFF;

  // ----------------------------------------------------------------
  // Order control fields
  // ----------------------------------------------------------------
  localparam int unsigned ROT_BASE = 0;
  localparam int unsigned SEL_BASE = 7;
  localparam int unsigned SEL_W    = 2;
  localparam int unsigned TOP_ARB  = 6;

  // ----------------------------------------------------------------
  // Source groups of the first-level arbiters
  // ----------------------------------------------------------------
  localparam int unsigned GROUP_BASE [0:5] = '{0, 4, 10, 16, 22, 28};
  localparam logic [5:0]  GROUP_WIDE = 6'h1E;

endpackage

// File: rtl/irq_priority_pending.sv
// IRQ priority resolution and pending-winner register with an APB slave.
`timescale 1ns/1ns
// What this block does
// - Order control register is readable, writable and resets to 0x7f.
// - Arbiters 1-3 order selects at [10:9],[12:11],[14:13] with four orders.
// - Arbiters 4 and 6 selects at [16:15],[20:19], same orders, reset zero.
// - Six-input arbiters: request 0 always first, request 5 always last.
// - Arbiter 0 select at [8:7] rotates ranking of requests 1 to 4.
// - Arbiter 5 select at [18:17], same rotating orders, resets zero.
// - Bit n enables rotation of arbiter n, each resets to one.
// - Pending-winner bit set only for highest unblocked waiting request.
// - At most one pending-winner bit set; it drives the IRQ line.
// - Writing ones clears pending-winner bits; zeros leave them alone.
// - Fast-routed sources never set a pending-winner bit.
// - Pending-winner bit shows a raised request; register resets to zero.
// - Bit 31 pen/converter, 27 two-wire, 26/25 USB, 0 external group a.
// - Route bit one sends a source to fast path; all reset to IRQ.
// - Block bit keeps a source out of arbitration only.
// - Read-only winner index holds the set bit number, clears with it.
module irq_priority_pending (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [31:0] source_request_latch,
  output logic      [31:0] fast_route_select,
  output logic      [31:0] source_block_bits,
  output logic             irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [31:0] route;
    logic [31:0] block;
    logic [31:0] order;
    logic [31:0] pending;
    logic [4:0]  index;
    logic [31:0] rdata;
    logic        ready;
    logic        err;
    logic        irq;
  } state_t;

  state_t st;
  state_t next_st;

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  // Result is {valid, index}. Requests 1 to 4 rotate with the select;
  // a four-input group simply never raises requests 0 and 5.
  function automatic logic [3:0] pick(
    input logic [5:0] req,
    input logic [1:0] sel
  );
    logic [3:0] res;
    logic [1:0] k;
    res = 4'h0;
    if (req[5]) begin
      res = {1'b1, 3'd5};
    end
    for (int i = 3; i >= 0; i--) begin
      k = 2'(sel + 2'(i));
      if (req[3'(k) + 3'd1]) begin
        res = {1'b1, 3'(k) + 3'd1};
      end
    end
    if (req[0]) begin
      res = {1'b1, 3'd0};
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // Candidate requests
  // ----------------------------------------------------------------
  logic [31:0] cand;
  logic [5:0]  top_req;
  logic [3:0]  top_pick;
  logic [3:0]  grp_pick [0:5];
  logic [4:0]  grp_src  [0:5];

  // Blocked sources still latch outside; only arbitration ignores them.
  assign cand = source_request_latch & ~st.block & ~st.route;

  genvar g;
  generate
    for (g = 0; g < 6; g++) begin : grp
      logic [5:0] req;
      logic [1:0] sel;
      if (irq_pkg::GROUP_WIDE[g]) begin : wide
        assign req = cand[irq_pkg::GROUP_BASE[g] +: 6];
        assign grp_src[g] = 5'(irq_pkg::GROUP_BASE[g])
                          + 5'(grp_pick[g][2:0]);
      end else begin : narrow
        assign req = {1'b0, cand[irq_pkg::GROUP_BASE[g] +: 4], 1'b0};
        assign grp_src[g] = 5'(irq_pkg::GROUP_BASE[g])
                          + 5'(grp_pick[g][2:0]) - 5'd1;
      end
      assign sel = st.order[irq_pkg::SEL_BASE + irq_pkg::SEL_W * g +: 2];
      assign grp_pick[g] = pick(req, sel);
      assign top_req[g] = grp_pick[g][3];
    end
  endgenerate

  // ----------------------------------------------------------------
  // Top arbiter
  // ----------------------------------------------------------------
  // Group 0 enters as request 0 and group 5 as request 5, so those two
  // groups keep their fixed rank whatever the top select says.
  logic [1:0] top_sel;

  assign top_sel  = st.order[irq_pkg::SEL_BASE + irq_pkg::SEL_W * irq_pkg::TOP_ARB +: 2];
  assign top_pick = pick(top_req, top_sel);

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  logic        setup;
  logic        commit;
  logic        known;
  logic [31:0] rd_mux;

  assign setup  = psel & ~penable;
  assign commit = psel & penable & st.ready & pwrite;

  always_comb begin
    known  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      irq_pkg::ADDR_ROUTE: begin
        rd_mux = st.route;
      end
      irq_pkg::ADDR_BLOCK: begin
        rd_mux = st.block;
      end
      irq_pkg::ADDR_ORDER: begin
        rd_mux = st.order;
      end
      irq_pkg::ADDR_PENDING: begin
        rd_mux = st.pending;
      end
      irq_pkg::ADDR_INDEX: begin
        rd_mux = {27'h0, st.index};
      end
      default: begin
        known = 1'b0;
      end
    endcase
  end

  // ----------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------
  logic [31:0] resp_rdata;
  logic        resp_err;

  // Read data is captured at setup, so the access phase never waits.
  always_comb begin
    resp_rdata = 32'h0000_0000;
    resp_err   = 1'b0;
    if (setup) begin
      resp_err = ~known;
      if (!pwrite) begin
        resp_rdata = rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write decode
  // ----------------------------------------------------------------
  logic wr_route;
  logic wr_block;
  logic wr_order;
  logic wr_pending;

  // The index register is read only: a write to it is dropped quietly.
  always_comb begin
    wr_route   = 1'b0;
    wr_block   = 1'b0;
    wr_order   = 1'b0;
    wr_pending = 1'b0;
    if (commit) begin
      case (paddr)
        irq_pkg::ADDR_ROUTE: begin
          wr_route = 1'b1;
        end
        irq_pkg::ADDR_BLOCK: begin
          wr_block = 1'b1;
        end
        irq_pkg::ADDR_ORDER: begin
          wr_order = 1'b1;
        end
        irq_pkg::ADDR_PENDING: begin
          wr_pending = 1'b1;
        end
        default: begin
          wr_pending = 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Winner selection
  // ----------------------------------------------------------------
  logic       take;
  logic [2:0] win_grp;
  logic [2:0] win_req;
  logic [4:0] win_src;

  // A new winner is taken only while nothing is pending, which keeps
  // the register one-hot without a second comparison stage.
  assign take    = (st.pending == 32'h0000_0000) && top_pick[3];
  assign win_grp = top_pick[2:0];

  always_comb begin
    win_req = 3'd0;
    win_src = 5'd0;
    for (int i = 0; i < 6; i++) begin
      if (3'(i) == win_grp) begin
        win_req = grp_pick[i][2:0];
        win_src = grp_src[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // Rotation
  // ----------------------------------------------------------------
  logic        grp_rot;
  logic        top_rot;
  logic [31:0] rot_order;

  // Requests 0 and 5 hold fixed ranks, so a win by either leaves a select alone.
  assign grp_rot = st.order[irq_pkg::ROT_BASE + 32'(win_grp)] &&
                   win_req >= 3'd1 && win_req <= 3'd4;
  assign top_rot = st.order[irq_pkg::ROT_BASE + irq_pkg::TOP_ARB] &&
                   win_grp >= 3'd1 && win_grp <= 3'd4;

  always_comb begin
    rot_order = st.order;
    if (top_rot) begin
      rot_order[irq_pkg::SEL_BASE + irq_pkg::SEL_W * irq_pkg::TOP_ARB +: 2] = win_grp[1:0];
    end
    if (grp_rot) begin
      rot_order[irq_pkg::SEL_BASE + irq_pkg::SEL_W * 32'(win_grp) +: 2] = win_req[1:0];
    end
  end

  // ----------------------------------------------------------------
  // Pending update
  // ----------------------------------------------------------------
  logic [31:0] clr;
  logic [31:0] set;
  logic [31:0] pend_next;

  always_comb begin
    set = 32'h0000_0000;
    clr = 32'h0000_0000;
    if (take) begin
      set[win_src] = 1'b1;
    end
    if (wr_pending) begin
      clr = pwdata;
    end
  end

  // Set wins over a clear that lands in the same cycle.
  assign pend_next = (st.pending & ~clr) | set;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    next_st       = st;
    next_st.ready = setup;
    next_st.rdata = resp_rdata;
    next_st.err   = resp_err;

    if (take) begin
      next_st.index = win_src;
      next_st.order = rot_order;
    end

    // Software writes; order writes win over a same-cycle rotation.
    if (wr_route) begin
      next_st.route = pwdata;
    end
    if (wr_block) begin
      next_st.block = pwdata;
    end
    if (wr_order) begin
      next_st.order = pwdata & irq_pkg::ORDER_MASK;
    end

    next_st.pending = pend_next;
    if (pend_next == 32'h0000_0000) begin
      next_st.index = irq_pkg::RST_INDEX;
    end
    next_st.irq = |pend_next;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st.route   <= irq_pkg::RST_ROUTE;
      st.block   <= irq_pkg::RST_BLOCK;
      st.order   <= irq_pkg::RST_ORDER;
      st.pending <= irq_pkg::RST_PENDING;
      st.index   <= irq_pkg::RST_INDEX;
      st.rdata   <= 32'h0000_0000;
      st.ready   <= 1'b0;
      st.err     <= 1'b0;
      st.irq     <= 1'b0;
    end else begin
      st <= next_st;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata            = st.rdata;
  assign pready            = st.ready;
  assign pslverr           = st.err;
  assign fast_route_select = st.route;
  assign source_block_bits = st.block;
  assign irq               = st.irq;

endmodule // irq_priority_pending

// File: bench/irq_priority_pending_assertions.sv
// Concurrent checks on the ports of the priority and pending stage.
`timescale 1ns/1ns
module irq_priority_pending_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [31:0] source_request_latch,
  input wire logic [31:0] fast_route_select,
  input wire logic [31:0] source_block_bits,
  input wire logic        irq
);
  // ----------
  // Helpers
  // ----------
  logic [31:0] live;
  logic        hit;
  logic        clr_wr;
  assign live = source_request_latch & ~source_block_bits & ~fast_route_select;
  assign hit = paddr >= irq_pkg::ADDR_ROUTE && paddr <= irq_pkg::ADDR_INDEX
               && paddr[1:0] == 2'h0;
  assign clr_wr = psel && penable && pwrite && paddr == irq_pkg::ADDR_PENDING
                  && pwdata != 32'h0000_0000;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  // ----------
  // Properties
  // ----------
  a_ready_next: assert property (s_setup |=> pready)
    else $error("pready missing after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready stood longer than one cycle");
  a_err_unmapped: assert property ((s_setup and !hit) |=> pready && pslverr)
    else $error("unmapped address not refused");
  a_err_mapped: assert property ((s_setup and hit) |=> !pslverr)
    else $error("mapped address refused");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("read data outside access phase");
  a_irq_take: assert property (!irq && (|live) |=> irq)
    else $error("waiting request not taken");
  a_irq_idle: assert property (!irq && !(|live) |=> !irq)
    else $error("irq without an eligible request");
  a_irq_hold: assert property (irq && !clr_wr |=> irq)
    else $error("irq dropped without a clear");
  a_route_reset: assert property ($rose(presetn) |->
    source_block_bits == irq_pkg::RST_BLOCK && fast_route_select == irq_pkg::RST_ROUTE)
    else $error("route or block reset value wrong");
endmodule  // irq_priority_pending_assertions

// File: bench/source_latch_model.sv
// Peripheral side: latched source requests feeding the stage.
`timescale 1ns/1ns
module source_latch_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [31:0] raise,
  input  wire logic [31:0] drop,
  output logic      [31:0] latch
);
  // Requests stay latched until software drops them, so none is lost in service.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      latch <= 32'h0000_0000;
    end else begin
      latch <= (latch | raise) & ~drop;
    end
  end
endmodule  // source_latch_model

// File: bench/tb_irq_priority_pending.sv
// Self-checking bench for the priority and pending stage.
`timescale 1ns/1ns
module tb_irq_priority_pending;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic [31:0] paddr, pwdata, prdata, latch, raise, drop, rd, route, block;
  int          bad_count, checks_done, b;
  irq_priority_pending u_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .source_request_latch(latch),
    .fast_route_select(route), .source_block_bits(block), .irq(irq));
  source_latch_model u_src (.pclk(pclk), .presetn(presetn), .raise(raise),
    .drop(drop), .latch(latch));
  initial begin
    pclk = 1'b0;
    forever #50 pclk = ~pclk;
  end
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rchk(input string n, input logic [31:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0000_0000);
    chk(n, rd, e);
  endtask
  task automatic pulse(input logic to_drop, input logic [31:0] v);
    @(posedge pclk);
    if (to_drop) begin
      drop <= v;
    end else begin
      raise <= v;
    end
    @(posedge pclk);
    drop <= 32'h0000_0000;
    raise <= 32'h0000_0000;
  endtask
  // Raise a set of sources, check the winner, then service it as software must.
  task automatic serve(input logic [31:0] req, input logic [31:0] ord,
                       input logic [31:0] win, input logic [31:0] ord_after);
    apb(1'b1, irq_pkg::ADDR_ORDER, ord);
    pulse(1'b0, req);
    rchk("pending", irq_pkg::ADDR_PENDING, win);
    chk("irq", {31'h0, irq}, 32'h1);
    rchk("index", irq_pkg::ADDR_INDEX, 32'($clog2(win)));
    rchk("order", irq_pkg::ADDR_ORDER, ord_after);
    apb(1'b1, irq_pkg::ADDR_PENDING, 32'h0000_0000);
    rchk("keep", irq_pkg::ADDR_PENDING, win);
    pulse(1'b1, req);
    apb(1'b1, irq_pkg::ADDR_PENDING, win);
    rchk("clear", irq_pkg::ADDR_PENDING, 32'h0000_0000);
    rchk("index0", irq_pkg::ADDR_INDEX, 32'h0000_0000);
    chk("irq0", {31'h0, irq}, 32'h0);
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    bad_count++;
    print_verdict();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, raise, drop} = '0;
    bad_count = 0;
    checks_done = 0;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    rchk("order_rst", irq_pkg::ADDR_ORDER, 32'h0000_007F);
    rchk("pend_rst", irq_pkg::ADDR_PENDING, 32'h0000_0000);
    rchk("route_rst", irq_pkg::ADDR_ROUTE, 32'h0000_0000);
    rchk("block_rst", irq_pkg::ADDR_BLOCK, 32'hFFFF_FFFF);
    apb(1'b0, 32'h4020_0000, 32'h0000_0000);
    chk("slverr", {31'h0, err}, 32'h1);
    apb(1'b1, irq_pkg::ADDR_ORDER, 32'hFFFF_FFFF);
    rchk("order_rw", irq_pkg::ADDR_ORDER, 32'h001F_FFFF);
    apb(1'b1, irq_pkg::ADDR_ROUTE, 32'h0000_0020);
    apb(1'b1, irq_pkg::ADDR_BLOCK, 32'h0000_0040);
    pulse(1'b0, 32'h0000_0060);
    chk("route_pin", route, 32'h0000_0020);
    chk("block_pin", block, 32'h0000_0040);
    rchk("fast_blk", irq_pkg::ADDR_PENDING, 32'h0000_0000);
    pulse(1'b1, 32'h0000_0060);
    apb(1'b1, irq_pkg::ADDR_INDEX, 32'h0000_001F);
    rchk("index_ro", irq_pkg::ADDR_INDEX, 32'h0000_0000);
    apb(1'b1, irq_pkg::ADDR_ROUTE, 32'h0000_0000);
    apb(1'b1, irq_pkg::ADDR_BLOCK, 32'h0000_0000);
    for (int c = 0; c < 4; c++) begin
      serve(32'hF, c << 7, 32'h1 << c, c << 7);
      serve(32'hF000_0000, c << 17, 32'h1000_0000 << c, c << 17);
      b = irq_pkg::GROUP_BASE[c + 1];
      serve(32'h1041_0410, c << 19, 32'h1 << b, c << 19);
      for (int g = 1; g < 5; g++) begin
        b = irq_pkg::GROUP_BASE[g];
        serve(32'h3F << b, c << (7 + 2 * g), 32'h1 << b, c << (7 + 2 * g));
        serve(32'h3E << b, c << (7 + 2 * g), 32'h2 << (b + c), c << (7 + 2 * g));
      end
    end
    serve(32'hF, 32'h1, 32'h1, 32'h81);
    serve(32'h1041_0410, 32'h40, 32'h10, 32'h0008_0040);
    print_verdict();
  end
endmodule  // tb_irq_priority_pending
bind irq_priority_pending irq_priority_pending_assertions u_chk (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .source_request_latch(source_request_latch), .fast_route_select(fast_route_select),
  .source_block_bits(source_block_bits), .irq(irq));
